// file: mscm_manual_switch.sv
`timescale 1ns/1ps
`default_nettype none
module mscm_manual_switch #(
  parameter logic [6:0] DEV_ADDR = mscm_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic kit_mono_event,
  input  wire logic kit_stereo_event,
  input  wire logic kit_digital_stereo_event,
  output logic      kit_event_irq,
  output logic      dm_usb,
  output logic      dm_audio,
  output logic      dm_uart_tx,
  output logic      dm_audio_bias,
  output logic      dp_usb,
  output logic      dp_audio,
  output logic      dp_uart_rx,
  output logic      dp_audio_bias,
  output logic      vbus_charger,
  output logic      vbus_microphone_path,
  output logic      id_video,
  output logic      id_bypass,
  output logic      boot_level_output,
  output logic      factory_power_up_pull_out,
  output logic      factory_power_up_pull_oe
);

  typedef enum logic [2:0] {
    MSCM_IDLE, MSCM_ADDR, MSCM_PTR, MSCM_WR, MSCM_ACK_OUT, MSCM_RD, MSCM_ACK_IN
  } mscm_state_t;

  mscm_reg_if bus ();

  logic [mscm_pkg::KIT_WIDTH-1:0] kit_status_reg;
  logic [mscm_pkg::KIT_WIDTH-1:0] kit_mask_reg;
  logic [7:0]                     line_reg;
  logic [mscm_pkg::AUX_WIDTH-1:0] aux_reg;

  logic        scl_meta_reg;
  logic        scl_sync_reg;
  logic        scl_prev_reg;
  logic        sda_meta_reg;
  logic        sda_sync_reg;
  logic        sda_prev_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  mscm_state_t state_reg;
  mscm_state_t after_ack_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  ptr_reg;
  logic        ack_due_reg;
  logic        host_ack_reg;
  logic        drive_low_reg;
  logic [7:0]  byte_in;
  logic        wr_pulse;
  logic        rd_pulse;

  // 3-bit data-line decode, unlisted codes give all open
  function automatic logic [3:0] mscm_dec3(input logic [2:0] code);
    logic [3:0] sel;
    sel = 4'h0;
    case (code)
      mscm_pkg::ROUTE3_USB:   sel = 4'h1;
      mscm_pkg::ROUTE3_AUDIO: sel = 4'h2;
      mscm_pkg::ROUTE3_UART:  sel = 4'h4;
      mscm_pkg::ROUTE3_BIAS:  sel = 4'h8;
      default:                sel = 4'h0;
    endcase
    return sel;
  endfunction

  // 2-bit decode, code 11 gives all open
  function automatic logic [1:0] mscm_dec2(input logic [1:0] code);
    logic [1:0] sel;
    sel = 2'h0;
    case (code)
      mscm_pkg::ROUTE2_FIRST:  sel = 2'h1;
      mscm_pkg::ROUTE2_SECOND: sel = 2'h2;
      default:                 sel = 2'h0;
    endcase
    return sel;
  endfunction

  // two-stage synchronisers, then one history stage for edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // bus conditions
  assign scl_rise   = scl_sync_reg && !scl_prev_reg;
  assign scl_fall   = !scl_sync_reg && scl_prev_reg;
  assign start_seen = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
  assign stop_seen  = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;
  assign byte_in    = {shift_reg[6:0], sda_sync_reg};

  // register strobes: write on the last data bit, read on byte load
  assign wr_pulse = (state_reg == MSCM_WR) && scl_rise && (bit_reg == mscm_pkg::BIT_LAST);
  assign rd_pulse = scl_fall && (((state_reg == MSCM_ACK_OUT) && (after_ack_reg == MSCM_RD))
                    || ((state_reg == MSCM_ACK_IN) && host_ack_reg));

  assign bus.addr  = ptr_reg;
  assign bus.wdata = byte_in;
  assign bus.wr    = wr_pulse;
  assign bus.rd    = rd_pulse;

  // serial protocol engine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= MSCM_IDLE;
      after_ack_reg <= MSCM_IDLE;
      bit_reg       <= 3'h0;
      shift_reg     <= 8'h00;
      ack_due_reg   <= 1'b0;
      host_ack_reg  <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (start_seen) begin
      state_reg     <= MSCM_ADDR;
      bit_reg       <= 3'h0;
      ack_due_reg   <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (stop_seen) begin
      state_reg     <= MSCM_IDLE;
      ack_due_reg   <= 1'b0;
      drive_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        MSCM_ADDR, MSCM_PTR, MSCM_WR: begin
          if (scl_rise) begin
            shift_reg <= byte_in;
            bit_reg   <= bit_reg + 3'h1;
            if (bit_reg == mscm_pkg::BIT_LAST) begin
              ack_due_reg <= 1'b1;
              if (state_reg == MSCM_ADDR) begin
                if (byte_in[7:1] != DEV_ADDR) begin
                  state_reg   <= MSCM_IDLE;
                  ack_due_reg <= 1'b0;
                end
                after_ack_reg <= byte_in[0] ? MSCM_RD : MSCM_PTR;
              end else begin
                after_ack_reg <= MSCM_WR;
              end
            end
          end else if (scl_fall && ack_due_reg) begin
            ack_due_reg   <= 1'b0;
            drive_low_reg <= 1'b1;
            state_reg     <= MSCM_ACK_OUT;
          end
        end
        MSCM_ACK_OUT: begin
          if (scl_fall) begin
            bit_reg   <= 3'h0;
            state_reg <= after_ack_reg;
            if (after_ack_reg == MSCM_RD) begin
              shift_reg     <= bus.rdata;
              drive_low_reg <= !bus.rdata[7];
            end else begin
              drive_low_reg <= 1'b0;
            end
          end
        end
        MSCM_RD: begin
          if (scl_fall) begin
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == mscm_pkg::BIT_LAST) begin
              drive_low_reg <= 1'b0;
              state_reg     <= MSCM_ACK_IN;
            end else begin
              shift_reg     <= {shift_reg[6:0], 1'b0};
              drive_low_reg <= !shift_reg[6];
            end
          end
        end
        MSCM_ACK_IN: begin
          if (scl_rise) begin
            host_ack_reg <= !sda_sync_reg;
          end else if (scl_fall) begin
            if (host_ack_reg) begin
              bit_reg       <= 3'h0;
              shift_reg     <= bus.rdata;
              drive_low_reg <= !bus.rdata[7];
              state_reg     <= MSCM_RD;
            end else begin
              state_reg <= MSCM_IDLE;
            end
          end
        end
        default: state_reg <= MSCM_IDLE;
      endcase
    end
  end

  // register pointer: set by the pointer byte, steps after each access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= 8'h00;
    end else if ((state_reg == MSCM_PTR) && scl_rise && (bit_reg == mscm_pkg::BIT_LAST)) begin
      ptr_reg <= byte_in;
    end else if (wr_pulse || rd_pulse) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // open-drain data pin: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_reg;

  mscm_regs u_regs (
    .clk_sys                  (clk_sys),
    .rst_n                    (rst_n),
    .bus                      (bus.slave),
    .kit_mono_event           (kit_mono_event),
    .kit_stereo_event         (kit_stereo_event),
    .kit_digital_stereo_event (kit_digital_stereo_event),
    .kit_status_reg           (kit_status_reg),
    .kit_mask_reg             (kit_mask_reg),
    .line_reg                 (line_reg),
    .aux_reg                  (aux_reg)
  );

  // registered switch and pin controls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {dm_audio_bias, dm_uart_tx, dm_audio, dm_usb} <= 4'h0;
      {dp_audio_bias, dp_uart_rx, dp_audio, dp_usb} <= 4'h0;
      {vbus_microphone_path, vbus_charger}          <= 2'h0;
      {id_bypass, id_video}                         <= 2'h0;
      boot_level_output                             <= 1'b0;
      factory_power_up_pull_oe                      <= 1'b0;
    end else begin
      {dm_audio_bias, dm_uart_tx, dm_audio, dm_usb} <=
        mscm_dec3(line_reg[mscm_pkg::DM_MSB:mscm_pkg::DM_LSB]);
      {dp_audio_bias, dp_uart_rx, dp_audio, dp_usb} <=
        mscm_dec3(line_reg[mscm_pkg::DP_MSB:mscm_pkg::DP_LSB]);
      {vbus_microphone_path, vbus_charger} <=
        mscm_dec2(line_reg[mscm_pkg::VBUS_MSB:mscm_pkg::VBUS_LSB]);
      {id_bypass, id_video} <=
        mscm_dec2(aux_reg[mscm_pkg::ID_MSB:mscm_pkg::ID_LSB]);
      boot_level_output        <= aux_reg[mscm_pkg::BOOT_BIT];
      factory_power_up_pull_oe <= aux_reg[mscm_pkg::PULL_BIT];
    end
  end

  // factory line is open drain: low when enabled, floating otherwise
  assign factory_power_up_pull_out = 1'b0;

  // masked car-kit events onto one level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kit_event_irq <= 1'b0;
    end else begin
      kit_event_irq <=
        (kit_status_reg[mscm_pkg::KIT_DIGITAL_STEREO_BIT]
         && !kit_mask_reg[mscm_pkg::KIT_DIGITAL_STEREO_BIT])
        || (kit_status_reg[mscm_pkg::KIT_STEREO_BIT]
         && !kit_mask_reg[mscm_pkg::KIT_STEREO_BIT])
        || (kit_status_reg[mscm_pkg::KIT_MONO_BIT]
         && !kit_mask_reg[mscm_pkg::KIT_MONO_BIT]);
    end
  end

endmodule
`default_nettype wire

// file: mscm_pkg.sv
package mscm_pkg;

  // register byte addresses on the serial port
  localparam logic [7:0] ADDR_KIT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_KIT_MASK   = 8'h12;
  localparam logic [7:0] ADDR_LINE       = 8'h13;
  localparam logic [7:0] ADDR_AUX        = 8'h14;

  // car-kit event bit positions (status and mask alike)
  localparam int KIT_DIGITAL_STEREO_BIT = 2;
  localparam int KIT_STEREO_BIT         = 1;
  localparam int KIT_MONO_BIT           = 0;
  localparam int KIT_WIDTH              = 3;

  // line routing field positions
  localparam int DM_MSB   = 7;
  localparam int DM_LSB   = 5;
  localparam int DP_MSB   = 4;
  localparam int DP_LSB   = 2;
  localparam int VBUS_MSB = 1;
  localparam int VBUS_LSB = 0;

  // aux routing field positions
  localparam int BOOT_BIT = 3;
  localparam int PULL_BIT = 2;
  localparam int ID_MSB   = 1;
  localparam int ID_LSB   = 0;
  localparam int AUX_WIDTH = 4;

  // reset values, and the read value of unmapped addresses
  localparam logic [7:0] KIT_STATUS_RST = 8'h00;
  localparam logic [7:0] KIT_MASK_RST   = 8'h00;
  localparam logic [7:0] LINE_RST       = 8'h00;
  localparam logic [7:0] AUX_RST        = 8'h00;
  localparam logic [7:0] READ_NONE      = 8'h00;

  // routing codes of the 3-bit data-line fields
  localparam logic [2:0] ROUTE3_OPEN  = 3'h0;
  localparam logic [2:0] ROUTE3_USB   = 3'h1;
  localparam logic [2:0] ROUTE3_AUDIO = 3'h2;
  localparam logic [2:0] ROUTE3_UART  = 3'h3;
  localparam logic [2:0] ROUTE3_BIAS  = 3'h4;

  // routing codes of the 2-bit fields
  localparam logic [1:0] ROUTE2_OPEN   = 2'h0;
  localparam logic [1:0] ROUTE2_FIRST  = 2'h1;
  localparam logic [1:0] ROUTE2_SECOND = 2'h2;

  // serial port
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h25; // arbitrary value
  localparam logic [2:0] BIT_LAST         = 3'h7;

endpackage

// file: mscm_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mscm_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;

  modport master (output addr, output wdata, output wr, output rd, input rdata);
  modport slave  (input addr, input wdata, input wr, input rd, output rdata);
endinterface
`default_nettype wire

// file: mscm_regs.sv
`timescale 1ns/1ps
`default_nettype none
module mscm_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  mscm_reg_if.slave                 bus,
  input  wire logic                 kit_mono_event,
  input  wire logic                 kit_stereo_event,
  input  wire logic                 kit_digital_stereo_event,
  output logic [mscm_pkg::KIT_WIDTH-1:0] kit_status_reg,
  output logic [mscm_pkg::KIT_WIDTH-1:0] kit_mask_reg,
  output logic [7:0]                line_reg,
  output logic [mscm_pkg::AUX_WIDTH-1:0] aux_reg
);

  logic [mscm_pkg::KIT_WIDTH-1:0] kit_set;
  logic [mscm_pkg::KIT_WIDTH-1:0] kit_status_next;
  logic                           status_rd;

  // gather car-kit events into status positions
  always_comb begin
    kit_set = '0;
    kit_set[mscm_pkg::KIT_MONO_BIT]           = kit_mono_event;
    kit_set[mscm_pkg::KIT_STEREO_BIT]         = kit_stereo_event;
    kit_set[mscm_pkg::KIT_DIGITAL_STEREO_BIT] = kit_digital_stereo_event;
  end

  assign status_rd = bus.rd && (bus.addr == mscm_pkg::ADDR_KIT_STATUS);

  // read clears, a fresh event in the same cycle survives
  always_comb begin
    kit_status_next = kit_status_reg;
    if (status_rd) begin
      kit_status_next = '0;
    end
    kit_status_next = kit_status_next | kit_set;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kit_status_reg <= mscm_pkg::KIT_STATUS_RST[mscm_pkg::KIT_WIDTH-1:0];
    end else begin
      kit_status_reg <= kit_status_next;
    end
  end

  // writable registers, reserved bits not stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kit_mask_reg <= mscm_pkg::KIT_MASK_RST[mscm_pkg::KIT_WIDTH-1:0];
      line_reg     <= mscm_pkg::LINE_RST;
      aux_reg      <= mscm_pkg::AUX_RST[mscm_pkg::AUX_WIDTH-1:0];
    end else if (bus.wr) begin
      case (bus.addr)
        mscm_pkg::ADDR_KIT_MASK: kit_mask_reg <= bus.wdata[mscm_pkg::KIT_WIDTH-1:0];
        mscm_pkg::ADDR_LINE:     line_reg     <= bus.wdata;
        mscm_pkg::ADDR_AUX:      aux_reg      <= bus.wdata[mscm_pkg::AUX_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // read mux, reserved and unmapped read as zero
  always_comb begin
    case (bus.addr)
      mscm_pkg::ADDR_KIT_STATUS: bus.rdata = {5'h00, kit_status_reg};
      mscm_pkg::ADDR_KIT_MASK:   bus.rdata = {5'h00, kit_mask_reg};
      mscm_pkg::ADDR_LINE:       bus.rdata = line_reg;
      mscm_pkg::ADDR_AUX:        bus.rdata = {4'h0, aux_reg};
      default:                   bus.rdata = mscm_pkg::READ_NONE;
    endcase
  end

endmodule
`default_nettype wire

// file: mscm_manual_switch_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mscm_manual_switch_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic kit_mono_event,
  input wire logic kit_stereo_event,
  input wire logic kit_digital_stereo_event,
  input wire logic kit_event_irq,
  input wire logic dm_usb,
  input wire logic dm_audio,
  input wire logic dm_uart_tx,
  input wire logic dm_audio_bias,
  input wire logic dp_usb,
  input wire logic dp_audio,
  input wire logic dp_uart_rx,
  input wire logic dp_audio_bias,
  input wire logic vbus_charger,
  input wire logic vbus_microphone_path,
  input wire logic id_video,
  input wire logic id_bypass,
  input wire logic boot_level_output,
  input wire logic factory_power_up_pull_out,
  input wire logic factory_power_up_pull_oe
);
  // any car-kit source pulsing
  wire       any_ev = kit_mono_event | kit_stereo_event | kit_digital_stereo_event;
  // all routing and level outputs
  wire [13:0] route = {dm_usb, dm_audio, dm_uart_tx, dm_audio_bias, dp_usb, dp_audio,
    dp_uart_rx, dp_audio_bias, vbus_charger, vbus_microphone_path, id_video, id_bypass,
    boot_level_output, factory_power_up_pull_oe};
  // scl pin history, idle high
  logic [4:0] scl_hist = 5'h1f;
  always_ff @(posedge clk_sys) begin
    scl_hist <= {scl_hist[3:0], scl_in};
  end
  // scl rose four samples ago: two synchroniser stages, one register commit and the output stage
  wire        scl_up = scl_hist[3] && !scl_hist[4];
  // a raised request holds for four cycles
  sequence s_stay;
    kit_event_irq [*4];
  endsequence
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  dm_onehot_a: assert property ($onehot0({dm_usb, dm_audio, dm_uart_tx, dm_audio_bias}))
    else $error("d-minus routing not one-hot");
  dp_onehot_a: assert property ($onehot0({dp_usb, dp_audio, dp_uart_rx, dp_audio_bias}))
    else $error("d-plus routing not one-hot");
  vbus_excl_a: assert property (!(vbus_charger && vbus_microphone_path))
    else $error("vbus routed two ways");
  id_excl_a: assert property (!(id_video && id_bypass))
    else $error("id routed two ways");
  pull_low_a: assert property (factory_power_up_pull_out == 1'b0)
    else $error("factory pull drives high");
  route_cause_a: assert property ($changed(route) |-> scl_up)
    else $error("routing moved without a bus commit");
  irq_rise_a: assert property ($rose(kit_event_irq) |-> $past(any_ev, 2) || scl_up)
    else $error("request raised without cause");
  irq_hold_a: assert property ($rose(kit_event_irq) |-> s_stay)
    else $error("request dropped early");
endmodule
bind mscm_manual_switch mscm_manual_switch_asserts chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .kit_mono_event(kit_mono_event),
  .kit_stereo_event(kit_stereo_event), .kit_digital_stereo_event(kit_digital_stereo_event),
  .kit_event_irq(kit_event_irq), .dm_usb(dm_usb), .dm_audio(dm_audio),
  .dm_uart_tx(dm_uart_tx), .dm_audio_bias(dm_audio_bias), .dp_usb(dp_usb),
  .dp_audio(dp_audio), .dp_uart_rx(dp_uart_rx), .dp_audio_bias(dp_audio_bias),
  .vbus_charger(vbus_charger), .vbus_microphone_path(vbus_microphone_path),
  .id_video(id_video), .id_bypass(id_bypass), .boot_level_output(boot_level_output),
  .factory_power_up_pull_out(factory_power_up_pull_out),
  .factory_power_up_pull_oe(factory_power_up_pull_oe));
`default_nettype wire

// file: mscm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mscm_host_model (
  input  wire logic clk_sys,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam int H = 8; // half scl period in clocks
  // bus idle: both lines released high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // sda moves only well inside scl low
  task automatic put(input logic b);
    w(3);
    sda_low <= !b;
    w(H - 3);
    scl <= 1'b1;
    w(H);
    scl <= 1'b0;
  endtask
  task automatic get(output logic b);
    w(3);
    sda_low <= 1'b0;
    w(H - 3);
    scl <= 1'b1;
    w(H / 2);
    b = sda;
    w(H / 2);
    scl <= 1'b0;
  endtask
  // start or repeated start
  task automatic start;
    w(3);
    sda_low <= 1'b0;
    w(H - 3);
    scl <= 1'b1;
    w(H);
    sda_low <= 1'b1;
    w(H);
    scl <= 1'b0;
  endtask
  task automatic stop;
    w(3);
    sda_low <= 1'b1;
    w(H - 3);
    scl <= 1'b1;
    w(H);
    sda_low <= 1'b0;
    w(H);
  endtask
  // msb first, then the ack slot
  task automatic send(input logic [7:0] d, output logic ok);
    logic b;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(b);
    ok = (b === 1'b0);
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] a, d, output logic ok);
    logic o1, o2, o3;
    start;
    send({dv, 1'b0}, o1);
    send(a, o2);
    send(d, o3);
    stop;
    ok = o1 & o2 & o3;
  endtask
  // pointer write, repeated start, one byte then nack
  task automatic rd(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d);
    logic o;
    start;
    send({dv, 1'b0}, o);
    send(a, o);
    start;
    send({dv, 1'b1}, o);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop;
  endtask
endmodule
`default_nettype wire

// file: mscm_manual_switch_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mscm_manual_switch_tb;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       scl, sda_low, sda_oe, sda_o, p_out, p_oe, irq, boot;
  logic [2:0] ev = 3'h0; // {digital stereo, stereo, mono}
  wire  [3:0] dm, dp;
  wire  [1:0] vb, id;
  wire        sda_in = !(sda_low | sda_oe); // pulled-up open drain
  int         n_errors = 0;
  int         n_tests = 0;
  localparam logic [6:0] DA = 7'h25; // arbitrary
  // clock
  initial forever #50 clk_sys = ~clk_sys;
  mscm_host_model host (.clk_sys(clk_sys), .scl(scl), .sda_low(sda_low), .sda(sda_in));
  mscm_manual_switch #(.DEV_ADDR(DA)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_o),
    .sda_oe(sda_oe), .kit_mono_event(ev[0]), .kit_stereo_event(ev[1]),
    .kit_digital_stereo_event(ev[2]), .kit_event_irq(irq), .dm_usb(dm[0]),
    .dm_audio(dm[1]), .dm_uart_tx(dm[2]), .dm_audio_bias(dm[3]), .dp_usb(dp[0]),
    .dp_audio(dp[1]), .dp_uart_rx(dp[2]), .dp_audio_bias(dp[3]), .vbus_charger(vb[0]),
    .vbus_microphone_path(vb[1]), .id_video(id[0]), .id_bypass(id[1]),
    .boot_level_output(boot), .factory_power_up_pull_out(p_out),
    .factory_power_up_pull_oe(p_oe));
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [3:0] dec3(input logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h4) ? 4'h1 << (c - 3'h1) : 4'h0;
  endfunction
  function automatic logic [1:0] dec2(input logic [1:0] c);
    return (c == 2'h1) ? 2'h1 : (c == 2'h2) ? 2'h2 : 2'h0;
  endfunction
  task automatic wreg(input logic [7:0] a, d);
    logic ok;
    host.wr(DA, a, d, ok);
    chk(ok, 1'b1);
  endtask
  task automatic rreg(input logic [7:0] a, exp);
    logic [7:0] d;
    host.rd(DA, a, d);
    chk(d, exp);
  endtask
  // one-cycle event pulse, then let status and request settle
  task automatic pulse(input int b);
    @(posedge clk_sys) ev <= 3'h1 << b;
    @(posedge clk_sys) ev <= 3'h0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    chk({dm, dp}, 8'h00);
    chk({vb, id, boot, p_oe, p_out, irq}, 8'h00);
    chk({sda_o, p_out}, 8'h00);
    rreg(8'h12, 8'h00);
    rreg(8'h13, 8'h00);
    rreg(8'h14, 8'h00);
    rreg(8'h10, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_line;
    logic [7:0] d;
    for (int c = 0; c < 8; c++) begin
      d = {c[2:0], c[2:0], c[1:0]}; // usb codes come with vbus on charger
      wreg(8'h13, d);
      chk(dm, dec3(c[2:0]));
      chk(dp, dec3(c[2:0]));
      chk(vb, dec2(c[1:0]));
      rreg(8'h13, d);
    end
    $display("t_line done");
  endtask
  task automatic t_aux;
    for (int k = 0; k < 16; k++) begin
      wreg(8'h14, {4'hf, k[3:0]});
      chk(boot, k[3]);
      chk({p_oe, p_out}, {k[2], 1'b0});
      chk(id, dec2(k[1:0]));
      rreg(8'h14, {4'h0, k[3:0]});
    end
    $display("t_aux done");
  endtask
  task automatic t_mask;
    wreg(8'h12, 8'hff);
    rreg(8'h12, 8'h07);
    for (int b = 0; b < 3; b++) begin
      wreg(8'h12, 8'h01 << b);
      pulse(b);
      chk(irq, 1'b0);
      rreg(8'h10, 8'h01 << b);
      rreg(8'h10, 8'h00);
      wreg(8'h12, 8'h07 ^ (8'h01 << b));
      pulse(b);
      chk(irq, 1'b1);
      rreg(8'h10, 8'h01 << b);
      chk(irq, 1'b0);
    end
    $display("t_mask done");
  endtask
  task automatic t_refuse;
    logic ok;
    host.wr(DA ^ 7'h01, 8'h13, 8'h24, ok);
    chk(ok, 1'b0);
    rreg(8'h13, 8'hff);
    chk(dm, 4'h0);
    wreg(8'h20, 8'h5a);
    rreg(8'h20, 8'h00);
    $display("t_refuse done");
  endtask
  // reset, then the scenarios
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset;
    t_line;
    t_aux;
    t_mask;
    t_refuse;
    close_out;
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire
